// ### common/ic_pkg.sv
// constants, carriers and state layout of the interrupt controller core
package ic_pkg;
  localparam int NUM_INT     = 8;     // ids 0..3 software generated, 4..7 shared
  localparam int NUM_SGI     = 4;
  localparam int NUM_LPI     = 4;
  localparam bit LPI_SUPPORT = 1'b1;
  localparam int ID_W        = LPI_SUPPORT ? 16 : $clog2(NUM_INT);
  localparam int PRIO_W      = 5;     // 32 levels
  localparam int LPI_PRIO_W  = 4;     // 16 levels, upper bits of the 5-bit scale

  localparam logic [15:0] LPI_BASE    = 16'h2000;
  localparam logic [15:0] SPURIOUS_ID = 16'h03FF;
  localparam logic [5:0]  PRIO_IDLE   = 6'h20;

  // register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_GROUP    = 8'h04;
  localparam logic [7:0] A_ENABLE   = 8'h08;
  localparam logic [7:0] A_SETPEND  = 8'h0C;
  localparam logic [7:0] A_CLRPEND  = 8'h10;
  localparam logic [7:0] A_MSGSET   = 8'h14;
  localparam logic [7:0] A_MSGCLR   = 8'h18;
  localparam logic [7:0] A_PRIO     = 8'h20;  // 8 words, one per id
  localparam logic [7:0] A_ACTIVE   = 8'h40;
  localparam logic [7:0] A_ACK      = 8'h44;
  localparam logic [7:0] A_EOI      = 8'h48;
  localparam logic [7:0] A_DSET     = 8'h50;
  localparam logic [7:0] A_DCLR     = 8'h54;
  localparam logic [7:0] A_DINV     = 8'h58;
  localparam logic [7:0] A_DINVALL  = 8'h5C;
  localparam logic [7:0] A_DSYNC    = 8'h60;
  localparam logic [7:0] A_PROPBASE = 8'h64;
  localparam logic [7:0] A_ERR      = 8'h68;
  localparam logic [7:0] A_PEND     = 8'h6C;
  localparam logic [7:0] A_LPIST    = 8'h70;

  // control bit positions
  localparam int CTRL_DGRP0 = 0;
  localparam int CTRL_CGRP0 = 2;
  localparam int CTRL_CGRP1 = 3;
  // property byte layout
  localparam int PROP_EN_BIT   = 0;
  localparam int PROP_PRIO_LSB = 4;

  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [31:0] PROP_RST = 32'h0000_0000;

  localparam logic [3:0] ERR_NONE     = 4'h0;
  localparam logic [3:0] ERR_BADMSG   = 4'h1;
  localparam logic [3:0] ERR_UNMAPPED = 4'h2;
  localparam logic [3:0] ERR_BADLPI   = 4'h3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ic_bus_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } ic_strm_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] idx;
    logic [7:0] props;
  } ic_fwd_s;

  typedef struct packed {
    logic [3:0]                          ctrl;
    logic [NUM_INT-1:0]                  grp;
    logic [NUM_INT-1:0]                  ena;
    logic [NUM_INT-1:0]                  pendReg;
    logic [NUM_INT-1:0]                  pendMsg;
    logic [NUM_INT-1:0]                  act;
    logic [NUM_INT-1:0][PRIO_W-1:0]      prio;
    logic [5:0]                          runPrio;
    logic                                outValid;
    logic [ID_W-1:0]                     outId;
    logic [PRIO_W-1:0]                   outPrio;
    logic                                recall;
    logic [31:0]                         propBase;
    logic [NUM_LPI-1:0]                  lpiPend;
    logic [NUM_LPI-1:0]                  cVal;
    logic [NUM_LPI-1:0]                  cEn;
    logic [NUM_LPI-1:0][LPI_PRIO_W-1:0]  cPrio;
    logic                                fetchBusy;
    logic [1:0]                          fetchIdx;
    logic [31:0]                         fetchAddr;
    logic                                errValid;
    logic [3:0]                          errCode;
    logic [31:0]                         rdata;
  } ic_state_s;
endpackage

// ### hdl/ic_core.sv
// interrupt controller core: pending, grouping, priority selection, locality cache
//
// The register offsets and the address-and-strobe port were decided locally.
module ic_core
  import ic_pkg::*;
#(
  parameter bit HAS_ITS = 1'b0
)
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            en,
  input  wire ic_bus_s         bus,
  output logic [31:0]          rdata,
  input  wire ic_strm_s        itsIn,
  output logic                 itsReady,
  input  wire ic_fwd_s         fwdIn,
  output logic                 fetchReq,
  output logic [31:0]          fetchAddr,
  input  wire logic            fetchAck,
  input  wire logic [7:0]      fetchData,
  output logic                 irqValid,
  output logic [ID_W-1:0]      irqId,
  output logic [PRIO_W-1:0]    irqPrio,
  output logic                 errFlag,
  output logic [3:0]           errCode
);
  localparam bit DIR_OK = LPI_SUPPORT && !HAS_ITS;

  ic_state_s          s;
  ic_state_s          n;
  logic [NUM_INT-1:0] pend;
  logic               selOk;
  logic [ID_W-1:0]    selId;
  logic [PRIO_W-1:0]  selPrio;
  logic [PRIO_W-1:0]  lp;
  logic [2:0]         wIdx;
  logic               hit;

  assign pend = s.pendReg | s.pendMsg;

  always_comb
  begin
    n       = s;
    selOk   = 1'b0;
    selId   = '0;
    selPrio = '1;
    lp      = '0;
    wIdx    = bus.addr[4:2];
    hit     = 1'b1;
    // selection: strict compare in ascending id order keeps the lowest id on ties
    for (int i = 0; i < NUM_INT; i++)
    begin
      if (pend[i] && s.ena[i] && !s.act[i] && s.ctrl[CTRL_CGRP0 + int'(s.grp[i])]
          && s.ctrl[CTRL_DGRP0 + int'(s.grp[i])] && (!selOk || s.prio[i] < selPrio))
      begin
        selOk   = 1'b1;
        selId   = ID_W'(i);
        selPrio = s.prio[i];
      end
    end
    for (int j = 0; j < NUM_LPI; j++)
    begin
      lp = {s.cPrio[j], 1'b0};
      if (s.lpiPend[j] && s.cVal[j] && s.cEn[j] && s.ctrl[CTRL_CGRP1]
          && (!selOk || lp < selPrio))
      begin
        selOk   = 1'b1;
        selId   = ID_W'(LPI_BASE) + ID_W'(j);
        selPrio = lp;
      end
    end
    // presentation, held off one cycle after a recall
    if (s.recall)
    begin
      n.recall   = 1'b0;
      n.outValid = 1'b0;
    end
    else
    begin
      n.outValid = selOk && ({1'b0, selPrio} < s.runPrio);
      n.outId    = selId;
      n.outPrio  = selPrio;
    end
    n.rdata = '0;
    // register writes
    if (bus.wr)
    begin
      if (bus.addr[7:5] == A_PRIO[7:5])
      begin
        n.prio[wIdx] = bus.wdata[PRIO_W-1:0];
        // active priority already captured in runPrio and stays
        if (s.outValid && s.outId == ID_W'(wIdx) && pend[wIdx] && !s.act[wIdx])
        begin
          n.recall   = 1'b1;
          n.outValid = 1'b0;
        end
      end
      else
      begin
        unique case (bus.addr)
          A_CTRL:     n.ctrl = bus.wdata[3:0];
          A_GROUP:    n.grp = bus.wdata[NUM_INT-1:0];
          A_ENABLE:   n.ena = bus.wdata[NUM_INT-1:0];
          A_SETPEND:  n.pendReg = s.pendReg | bus.wdata[NUM_INT-1:0];
          A_CLRPEND:  n.pendReg = s.pendReg & ~bus.wdata[NUM_INT-1:0];
          A_MSGSET, A_MSGCLR:
          begin
            if (bus.wdata[31:3] == '0 && bus.wdata[2:0] >= 3'(NUM_SGI))
              n.pendMsg[bus.wdata[2:0]] = (bus.addr == A_MSGSET);
            else
            begin
              n.errValid = 1'b1;
              n.errCode  = ERR_BADMSG;
            end
          end
          A_EOI:
          begin
            if (bus.wdata[31:3] == '0)
              n.act[bus.wdata[2:0]] = 1'b0;
            n.runPrio = PRIO_IDLE;
          end
          A_DSET, A_DCLR:
          begin
            if (DIR_OK && bus.wdata[15:2] == LPI_BASE[15:2])
              n.lpiPend[bus.wdata[1:0]] = (bus.addr == A_DSET);
            else if (DIR_OK)
            begin
              n.errValid = 1'b1;
              n.errCode  = ERR_BADLPI;
            end
          end
          A_DINV:     if (DIR_OK) n.cVal[bus.wdata[1:0]] = 1'b0;
          A_DINVALL:  if (DIR_OK) n.cVal = '0;
          A_DSYNC:    n.rdata = '0;
          A_PROPBASE: n.propBase = bus.wdata;
          A_ERR:      if (bus.wdata[0]) n.errValid = 1'b0;
          default:    hit = 1'b0;
        endcase
      end
    end
    // register reads, data stand in the following cycle
    if (bus.rd)
    begin
      if (bus.addr[7:5] == A_PRIO[7:5])
        n.rdata = 32'(s.prio[wIdx]);
      else
      begin
        unique case (bus.addr)
          A_CTRL:     n.rdata = 32'(s.ctrl);
          A_GROUP:    n.rdata = 32'(s.grp);
          A_ENABLE:   n.rdata = 32'(s.ena);
          A_PEND:     n.rdata = 32'({s.pendMsg, s.pendReg});
          A_ACTIVE:   n.rdata = 32'(s.act);
          A_PROPBASE: n.rdata = s.propBase;
          A_ERR:      n.rdata = 32'({s.errCode, s.errValid});
          A_LPIST:    n.rdata = 32'({s.cVal, s.lpiPend});
          A_ACK:
          begin
            n.rdata = s.outValid ? 32'(s.outId) : 32'(SPURIOUS_ID);
            if (s.outValid && !s.recall)
            begin
              n.runPrio  = {1'b0, s.outPrio};
              n.outValid = 1'b0;
              if (s.outId < ID_W'(NUM_INT))
              begin
                n.act[s.outId[2:0]]     = 1'b1;
                n.pendReg[s.outId[2:0]] = 1'b0;
                n.pendMsg[s.outId[2:0]] = 1'b0;
              end
              else
                n.lpiPend[s.outId[1:0]] = 1'b0;
            end
          end
          A_SETPEND, A_CLRPEND, A_MSGSET, A_MSGCLR, A_EOI, A_DSET, A_DCLR, A_DINV,
          A_DINVALL, A_DSYNC:
            n.rdata = '0;
          default:    hit = 1'b0;
        endcase
      end
    end
    if (!hit)
    begin
      n.errValid = 1'b1;
      n.errCode  = ERR_UNMAPPED;
    end
    // translation service messages, always accepted
    if (HAS_ITS && itsIn.valid)
    begin
      if (itsIn.data[15:2] == LPI_BASE[15:2])
        n.lpiPend[itsIn.data[1:0]] = 1'b1;
      else
      begin
        n.errValid = 1'b1;
        n.errCode  = ERR_BADLPI;
      end
    end
    // forwarded from a remote chip: properties travel with it and stay cached
    if (LPI_SUPPORT && fwdIn.valid)
    begin
      n.lpiPend[fwdIn.idx] = 1'b1;
      n.cVal[fwdIn.idx]    = 1'b1;
      n.cEn[fwdIn.idx]     = fwdIn.props[PROP_EN_BIT];
      n.cPrio[fwdIn.idx]   = fwdIn.props[PROP_PRIO_LSB +: LPI_PRIO_W];
    end
    // property fetch for pending entries without cached properties
    if (s.fetchBusy)
    begin
      if (fetchAck)
      begin
        n.fetchBusy          = 1'b0;
        n.cVal[s.fetchIdx]   = 1'b1;
        n.cEn[s.fetchIdx]    = fetchData[PROP_EN_BIT];
        n.cPrio[s.fetchIdx]  = fetchData[PROP_PRIO_LSB +: LPI_PRIO_W];
      end
    end
    else
    begin
      for (int k = NUM_LPI - 1; k >= 0; k--)
      begin
        if (s.lpiPend[k] && !s.cVal[k])
        begin
          n.fetchBusy = 1'b1;
          n.fetchIdx  = 2'(k);
          n.fetchAddr = s.propBase + 32'(LPI_BASE) + 32'(k);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s          <= '0;
      s.ctrl     <= CTRL_RST;
      s.propBase <= PROP_RST;
      s.runPrio  <= PRIO_IDLE;
      s.errCode  <= ERR_NONE;
    end
    else if (en)
      s <= n;
  end

  assign rdata     = s.rdata;
  assign itsReady  = 1'b1;
  assign fetchReq  = s.fetchBusy;
  assign fetchAddr = s.fetchAddr;
  assign irqValid  = s.outValid;
  assign irqId     = s.outId;
  assign irqPrio   = s.outPrio;
  assign errFlag   = s.errValid;
  assign errCode   = s.errCode;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence prioWriteHit;
    en && bus.wr && bus.addr[7:5] == A_PRIO[7:5] && s.outValid && !s.recall
      && s.outId == ID_W'(bus.addr[4:2]) && pend[bus.addr[4:2]] && !s.act[bus.addr[4:2]];
  endsequence
  sequence withdrawn;
    !irqValid ##1 !irqValid;
  endsequence

  AST_MSG_KEEP: assert property (en && bus.wr && bus.addr == A_CLRPEND |=>
    s.pendMsg == $past(s.pendMsg)) else $error("message pending lost on clear-pending");
  AST_REG_KEEP: assert property (en && bus.wr && bus.addr == A_MSGCLR |=>
    s.pendReg == $past(s.pendReg)) else $error("register pending lost on message clear");
  AST_GRP_WRITE: assert property (en && bus.wr && bus.addr == A_GROUP |=>
    s.grp == $past(bus.wdata[7:0])) else $error("group write not taken");
  AST_SGI_EN: assert property (en && bus.wr && bus.addr == A_ENABLE |=>
    s.ena[3:0] == $past(bus.wdata[3:0])) else $error("enable write not taken");
  AST_GRP_OFF: assert property (irqValid && irqId < ID_W'(NUM_INT) && $stable(s.ctrl)
    && $stable(s.grp) |-> s.ctrl[CTRL_CGRP0 + int'(s.grp[irqId[2:0]])])
    else $error("interrupt of disabled group presented");
  AST_LPI_LEVELS: assert property (irqValid && irqId >= ID_W'(LPI_BASE) |->
    !irqPrio[0]) else $error("locality interrupt off the 16-level scale");
  AST_PEND_SET: assert property (en && bus.wr && bus.addr == A_SETPEND |=>
    (s.pendReg & $past(bus.wdata[7:0])) == $past(bus.wdata[7:0]))
    else $error("set-pending not taken");
  AST_RECALL: assert property (prioWriteHit |=> withdrawn)
    else $error("pending interrupt not withdrawn after priority write");
  AST_RUN_KEEP: assert property (en && bus.wr && bus.addr[7:5] == A_PRIO[7:5] |=>
    s.runPrio == $past(s.runPrio)) else $error("active priority changed by priority write");
  AST_DIRECT_RAZ: assert property (!DIR_OK && en && bus.rd && bus.addr == A_DSYNC |=>
    rdata == '0) else $error("direct register not read as zero");
  AST_ITS_READY: assert property (itsReady)
    else $error("translation stream back-pressured");
  AST_ERR_LOG: assert property (en && (bus.wr || bus.rd) && bus.addr == 8'hFC
    && !itsIn.valid |=>
    errFlag && errCode == ERR_UNMAPPED) else $error("unmapped access not logged");
  AST_INV_ALL: assert property (DIR_OK && en && bus.wr && bus.addr == A_DINVALL
    && !fwdIn.valid && !fetchAck |=> s.cVal == '0) else $error("invalidate-all left entries");
  AST_FETCH_BASE: assert property ($rose(fetchReq) |->
    fetchAddr == $past(s.propBase) + 32'(LPI_BASE) + 32'(s.fetchIdx))
    else $error("fetch not from own property base");
endmodule

// ### verif/ic_prop_mem.sv
// property table model answering the core's fetches, prompt or slow
module ic_prop_mem
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        fetchReq,
  input  wire logic [31:0] fetchAddr,
  output logic             fetchAck,
  output logic [7:0]       fetchData
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      fetchAck <= 1'b0;
      fetchData <= 8'h00;
    end
    else
    begin
      fetchAck <= 1'b0;
      // stale byte is not held after the answer
      if (fetchAck)
        fetchData <= ~fetchData;
      if (cnt < 0)
        cnt <= cnt + 1;
      else if (fetchReq && cnt >= (slow ? 6 : 0))
      begin
        fetchAck <= 1'b1;
        fetchData <= {4'(fetchAddr[1:0]) + 4'h8, 4'h1};
        cnt <= -3;
      end
      else if (fetchReq)
        cnt <= cnt + 1;
    end
  end
endmodule

// ### verif/ic_core_tb.sv
// self-checking bench of the interrupt controller core
module ic_core_tb
  import ic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, en, slow, fAck, fReq, itsRdy, rdy2, irqV, errF;
  logic [31:0] rdata, rdata2, fAddr, d, d2, mBase, seed;
  logic [15:0] irqId;
  logic [7:0]  fData, mGrp, mEna, mPR, mPM, mAct;
  logic [4:0]  irqP;
  logic [3:0]  errC, mCtrl, mLp, mLc, mLe;
  ic_bus_s     bus;
  ic_fwd_s     fwd;
  ic_strm_s    its2;
  int          mPrio[8], mLpr[4], runP, bestP, b, cyc, numErrors, numChecks;

  ic_core #(.HAS_ITS(1'b0)) u_dut (.clk(clk), .rst_n(rst_n), .en(en), .bus(bus),
    .rdata(rdata), .itsIn(its2), .itsReady(itsRdy), .fwdIn(fwd), .fetchReq(fReq),
    .fetchAddr(fAddr), .fetchAck(fAck), .fetchData(fData), .irqValid(irqV),
    .irqId(irqId), .irqPrio(irqP), .errFlag(errF), .errCode(errC));
  ic_core #(.HAS_ITS(1'b1)) u_its (.clk(clk), .rst_n(rst_n), .en(en), .bus(bus),
    .rdata(rdata2), .itsIn(its2), .itsReady(rdy2), .fwdIn(fwd), .fetchReq(),
    .fetchAddr(), .fetchAck(1'b0), .fetchData(8'h00), .irqValid(), .irqId(),
    .irqPrio(), .errFlag(), .errCode());
  ic_prop_mem u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .fetchReq(fReq),
    .fetchAddr(fAddr), .fetchAck(fAck), .fetchData(fData));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic testDone();
    $display("checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      numErrors++;
      testDone();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sampled away from the launching edge
  always @(negedge clk)
    if (rst_n && fReq)
      chk({fAddr[31:2], 2'b00}, mBase + 32'h0000_2000);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected presented id, 1023 when none; lowest value, then lowest id
  function automatic int best();
    int   p;
    logic g;
    logic e;
    best = 1023;
    bestP = 32;
    for (int i = 0; i < 12; i++)
    begin
      g = (i < 8) ? mGrp[i[2:0]] : 1'b1;
      e = (i < 8) ? (mPR[i[2:0]] | mPM[i[2:0]]) & mEna[i[2:0]] & ~mAct[i[2:0]]
                  : mLp[i[1:0]] & mLc[i[1:0]] & mLe[i[1:0]];
      p = (i < 8) ? mPrio[i[2:0]] : mLpr[i[1:0]];
      // locality interrupts are gated by the cpu group 1 enable only
      if (e && mCtrl[2 + g] && (i >= 8 || mCtrl[g]) && p < bestP && p < runP)
      begin
        best = (i < 8) ? i : 32'h0000_2000 + i - 8;
        bestP = p;
      end
    end
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
    d2 = rdata2;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  // write and update the bench model
  task automatic wm(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    case (a)
      A_CTRL:     mCtrl = v[3:0];
      A_GROUP:    mGrp = v[7:0];
      A_ENABLE:   mEna = v[7:0];
      A_SETPEND:  mPR |= v[7:0];
      A_CLRPEND:  mPR &= ~v[7:0];
      A_MSGSET:   mPM[v[2:0]] = 1'b1;
      A_MSGCLR:   mPM[v[2:0]] = 1'b0;
      A_DSET:     mLp[v[1:0]] = 1'b1;
      A_DCLR:     mLp[v[1:0]] = 1'b0;
      A_DINV:     mLc[v[1:0]] = 1'b0;
      A_DINVALL:  mLc = '0;
      A_PROPBASE: mBase = v;
      default:    if (a >= A_PRIO && a < A_ACTIVE) mPrio[(a - A_PRIO) >> 2] = v[4:0];
    endcase
  endtask

  task automatic ck();
    repeat (4) @(posedge clk);
    #1;
    b = best();
    chk(irqV, b != 1023);
    if (b != 1023)
    begin
      chk(irqId, b);
      chk(irqP, bestP);
    end
  endtask

  initial
  begin
    bus = '0;
    en = 1'b1;
    fwd = '0;
    its2 = '0;
    slow = 1'b0;
    rst_n = 1'b0;
    seed = 32'h0000_9B8F;
    {mGrp, mEna, mPR, mPM, mAct, mCtrl, mLp, mLc, mLe, mBase} = '0;
    runP = 32;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rc(A_PROPBASE, 32'h0000_0000);
    chk($bits(u_dut.irqId), 16);
    chk(itsRdy, 1'b1);
    chk(rdy2, 1'b1);
    wm(A_GROUP, 32'h0000_00F0);
    wm(A_ENABLE, 32'h0000_00FF);
    rc(A_GROUP, 32'h0000_00F0);
    rc(A_ENABLE, 32'h0000_00FF);
    for (int i = 0; i < 8; i++)
      wm(A_PRIO + 8'(4 * i), xs() % 30 + 2);
    wm(A_PRIO + 8'h08, 32'h0000_0001);
    wm(A_PRIO + 8'h0C, 32'h0000_0001);
    wm(A_CTRL, 32'h0000_000C);
    wm(A_SETPEND, 32'h0000_000F);
    for (int i = 4; i < 8; i++)
      wm(A_MSGSET, i);
    rc(A_PEND, {mPM, mPR});
    ck();
    wm(A_CLRPEND, 32'h0000_00FF);
    rc(A_PEND, {mPM, mPR});
    wm(A_SETPEND, 32'h0000_004F);
    wm(A_MSGCLR, 32'h0000_0006);
    rc(A_PEND, {mPM, mPR});
    for (int c = 0; c < 16; c++)
    begin
      wm(A_CTRL, c);
      ck();
    end
    wm(A_CTRL, 32'h0000_000F);
    b = best();
    wm(A_PRIO + 8'(4 * b), xs() % 32);
    #1;
    chk(irqV, 1'b0);
    @(posedge clk);
    #1;
    chk(irqV, 1'b0);
    ck();
    rd(A_ACK);
    b = best();
    chk(d, b);
    mAct[b[2:0]] = 1'b1;
    mPR[b[2:0]] = 1'b0;
    mPM[b[2:0]] = 1'b0;
    runP = bestP;
    wm(A_PRIO + 8'(4 * b), 32'h0000_0000);
    ck();
    rc(A_ACTIVE, mAct);
    wm(A_EOI, b);
    mAct = '0;
    runP = 32;
    ck();
    wm(A_PROPBASE, 32'h0001_0000);
    rc(A_PROPBASE, 32'h0001_0000);
    for (int i = 0; i < 2; i++)
    begin
      slow <= i[0];
      wm(A_DSET, 32'h0000_2000 + i);
      mLc[i] = 1'b1;
      mLe[i] = 1'b1;
      mLpr[i] = 2 * (i + 8);
      repeat (12) @(posedge clk);
      rc(A_LPIST, {mLc, mLp});
      ck();
    end
    @(posedge clk);
    fwd <= '{valid: 1'b1, idx: 2'd3, props: 8'h30};
    its2 <= '{valid: 1'b1, data: 16'h2001};
    @(posedge clk);
    fwd.valid <= 1'b0;
    its2.valid <= 1'b0;
    mLp[3] = 1'b1;
    mLc[3] = 1'b1;
    mLe[3] = 1'b0;
    mLpr[3] = 6;
    rc(A_LPIST, {mLc, mLp});
    ck();
    wm(A_DCLR, 32'h0000_2003);
    wm(A_DINV, 32'h0000_0003);
    rc(A_LPIST, {mLc, mLp});
    chk(d2, 32'h0000_008A);
    wm(A_DINVALL, 32'h0000_0000);
    rc(A_LPIST, {mLc, mLp});
    rd(A_DSYNC);
    chk(d2, 32'h0000_0000);
    wr(A_MSGSET, 32'h0000_0002);
    rc(A_ERR, {ERR_BADMSG, 1'b1});
    wr(A_DSET, 32'h0000_3000);
    rc(A_ERR, {ERR_BADLPI, 1'b1});
    rc(8'hFC, 32'h0000_0000);
    chk(errF, 1'b1);
    chk(errC, ERR_UNMAPPED);
    rc(A_ERR, {ERR_UNMAPPED, 1'b1});
    wr(A_ERR, 32'h0000_0001);
    #1;
    chk(errF, 1'b0);
    // clock enable low: the group write must not land
    en <= 1'b0;
    wr(A_GROUP, 32'h0000_0000);
    en <= 1'b1;
    rc(A_GROUP, mGrp);
    testDone();
  end
endmodule
